// ---- hw/scm_regs.svh ----
// register offsets, field positions and reset values of the serial clock block
`ifndef SCM_REGS_SVH
`define SCM_REGS_SVH

// byte offsets of the register words
`define SCM_CTRL_OFS     8'h00
`define SCM_DIV_OFS      8'h04
`define SCM_RXT_OFS      8'h10
`define SCM_TXT_OFS      8'h18
`define SCM_RXH_OFS      8'h20
`define SCM_TXH_OFS      8'h24
`define SCM_STAT_OFS     8'h40
`define SCM_MASK_OFS     8'h4c

// control word fields
`define SCM_CTRL_RXEN    0
`define SCM_CTRL_TXEN    1

// timing word fields
`define SCM_T_SRC_LSB    0
`define SCM_T_DRV_LSB    2
`define SCM_T_FLIP       4
`define SCM_T_START_LSB  5
`define SCM_T_FSOUT      8
`define SCM_T_LEN_LSB    9

// status word fields
`define SCM_ST_TXACT     0
`define SCM_ST_TXFULL    1
`define SCM_ST_RXACT     2
`define SCM_ST_RXFULL    3
`define SCM_ST_PEND_LSB  4

// widths and reset values
`define SCM_DIV_W        12
`define SCM_PEND_W       3
`define SCM_TIMING_RST   14'h0000
`define SCM_DIV_RST      12'h000

`endif

// ---- hw/scm_pkg.sv ----
// types shared by the serial clock block and its divider
package scm_pkg;

  typedef enum logic [1:0] {
    SCM_SRC_DIV   = 2'h0,
    SCM_SRC_OTHER = 2'h1,
    SCM_SRC_PIN   = 2'h2
  } scm_src_t;

  typedef enum logic [1:0] {
    SCM_DRV_OFF  = 2'h0,
    SCM_DRV_CONT = 2'h1,
    SCM_DRV_XFER = 2'h2
  } scm_drv_t;

  typedef enum logic [2:0] {
    SCM_GO_CONT = 3'h0,
    SCM_GO_SYNC = 3'h1,
    SCM_GO_FALL = 3'h2,
    SCM_GO_RISE = 3'h3
  } scm_start_t;

  // gray coded side sequencer
  typedef enum logic [1:0] {
    SCM_IDLE = 2'b00,
    SCM_RUN  = 2'b01
  } scm_fsm_t;

  typedef struct packed {
    logic [4:0] len_m1;
    logic       fs_out;
    scm_start_t start;
    logic       flip;
    scm_drv_t   drv;
    scm_src_t   src;
  } scm_timing_t;

  typedef struct packed {
    logic clk_i;
    logic fs_i;
  } scm_pin_in_t;

  typedef struct packed {
    logic clk_o;
    logic clk_oe;
    logic fs_o;
    logic fs_oe;
    logic data_o;
  } scm_pin_out_t;

  typedef struct packed {
    scm_fsm_t    fsm;
    logic [4:0]  cnt;
    logic [31:0] shift;
    logic [31:0] hold;
    logic        full;
  } scm_side_t;

  typedef struct packed {
    logic [11:0] cnt;
    logic        clk;
  } scm_div_t;

  typedef struct packed {
    logic [1:0]   tx_clk_sync;
    logic [1:0]   rx_clk_sync;
    logic [1:0]   tx_fs_sync;
    logic [1:0]   rx_fs_sync;
    logic [1:0]   rx_dat_sync;
    logic         tx_fs_q;
    logic         rx_fs_q;
    logic         tx_int_q;
    logic         rx_int_q;
    logic         tx_go_q;
    logic         rx_go_q;
    scm_timing_t  txt;
    scm_timing_t  rxt;
    logic [11:0]  div;
    logic         tx_en;
    logic         rx_en;
    scm_side_t    tx;
    scm_side_t    rx;
    logic [2:0]   pend;
    logic [2:0]   mask;
    logic [31:0]  prdata;
    logic         pslverr;
    scm_pin_out_t txo;
    scm_pin_out_t rxo;
  } scm_state_t;

endpackage

// ---- hw/scm_clk_div.sv ----
// shared clock divider: 50% duty divided clock as a level in the pclk domain
`timescale 1ns/100ps
module scm_clk_div #(
  parameter int DIV_W = 12
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [DIV_W-1:0] div_val,
  output logic                  div_clk
);
  import scm_pkg::*;

  scm_div_t s_ff;
  scm_div_t nxt_s;

  // count from zero, toggle and restart after div_val cycles
  always_comb begin
    nxt_s = s_ff;
    if (div_val == '0) begin
      nxt_s = '0;
    end else if (s_ff.cnt >= div_val - 12'h001) begin
      nxt_s.cnt = 12'h000;
      nxt_s.clk = ~s_ff.clk;
    end else begin
      nxt_s.cnt = s_ff.cnt + 12'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign div_clk = s_ff.clk;

  ////////////////////////////////////////////////////////////////////////
  // helper: length of the level that just ended
  logic        prev_ff;
  logic        clean_ff;
  logic [12:0] ph_ff;
  logic        toggled;
  assign toggled = s_ff.clk != prev_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_ff  <= 1'b0;
      clean_ff <= 1'b0;
      ph_ff    <= 13'h0000;
    end else begin
      prev_ff <= s_ff.clk;
      ph_ff   <= toggled ? 13'h0001 : ph_ff + 13'h0001;
      if (div_val != $past(div_val)) begin
        clean_ff <= 1'b0;
      end else if (toggled) begin
        clean_ff <= 1'b1;
      end
    end
  end

  chk_div_idle_low: assert property (@(posedge pclk) disable iff (!presetn)
    div_val == '0 |=> !div_clk)
    else $error("divided clock runs while divide value is zero");

  chk_div_phase_len: assert property (@(posedge pclk) disable iff (!presetn)
    toggled && clean_ff && $stable(div_val) && div_val != '0 |-> ph_ff == {1'b0, div_val})
    else $error("divided clock level length differs from divide value");

  chk_div_period_two: assert property (@(posedge pclk) disable iff (!presetn)
    div_val == 12'h001 && $past(div_val) == 12'h001 && $past(div_val, 2) == 12'h001
      |-> div_clk != $past(div_clk))
    else $error("divide value one does not halve the bus clock");

  cov_div_toggle: cover property (@(posedge pclk) disable iff (!presetn) toggled && clean_ff);
endmodule

// ---- hw/scm_core.sv ----
// serial clock management: clock selection, pin drive, start and apb registers
// What this block does
// - divide value is a 12-bit field up to 4095, dividing by up to 8190
// - divide value zero keeps the divider idle with no divided clock
// - divided clock is bus clock over twice the divide value
// - each divided clock level lasts divide-value bus cycles, 50% duty
// - one divided clock feeds both transmitter and receiver
// - transmit source is own pin, receiver clock or divided clock
// - receive source is own pin, transmitter clock or divided clock
// - transmit inversion affects internal clock only, not the pin
// - receive inversion affects internal clock only, not the pin
// - transmit clock pin driven always, during transfer only, or never
// - receive clock pin driven always, during transfer only, or never
// - sides run independently, may share clock and start together
// - interrupt asserts while any pending source is unmasked; status readable
// - each side starts automatically or on frame sync events
// - transmit and receive serve dma with words up to 32 bits
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "scm_regs.svh"
module scm_core (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire scm_pkg::scm_pin_in_t tx_pins_in,
  input  wire scm_pkg::scm_pin_in_t rx_pins_in,
  input  wire logic               rx_data_i,
  output scm_pkg::scm_pin_out_t   tx_pins_out,
  output scm_pkg::scm_pin_out_t   rx_pins_out,
  output logic                    tx_dma_req,
  output logic                    rx_dma_req,
  output logic                    irq
);
  import scm_pkg::*;

  scm_state_t s_ff;
  scm_state_t nxt_s;
  logic       div_clk;

  ////////////////////////////////////////////////////////////////////////
  // one divider shared by both sides
  scm_clk_div #(.DIV_W(`SCM_DIV_W)) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .div_val (s_ff.div),
    .div_clk (div_clk)
  );

  ////////////////////////////////////////////////////////////////////////
  // decode helpers
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == `SCM_CTRL_OFS) || (a == `SCM_DIV_OFS) || (a == `SCM_RXT_OFS) ||
                 (a == `SCM_TXT_OFS) || (a == `SCM_RXH_OFS) || (a == `SCM_TXH_OFS) ||
                 (a == `SCM_STAT_OFS) || (a == `SCM_MASK_OFS);
  endfunction

  function automatic logic start_hit(input scm_start_t m, input logic fs_rise,
                                     input logic fs_fall, input logic other_go);
    case (m)
      SCM_GO_CONT: start_hit = 1'b1;
      SCM_GO_SYNC: start_hit = other_go;
      SCM_GO_FALL: start_hit = fs_fall;
      SCM_GO_RISE: start_hit = fs_rise;
      default:     start_hit = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // clock selection; a side taking the other's clock gets that side's own
  // source, so two sides pointing at each other fall back to the divider
  logic tx_own;
  logic rx_own;
  logic tx_base;
  logic rx_base;
  logic tx_int;
  logic rx_int;
  logic tx_rise;
  logic rx_rise;
  logic tx_fs_rise;
  logic tx_fs_fall;
  logic rx_fs_rise;
  logic rx_fs_fall;
  logic tx_go;
  logic rx_go;
  logic setup;
  logic access;

  assign tx_own  = (s_ff.txt.src == SCM_SRC_PIN) ? s_ff.tx_clk_sync[1] : div_clk;
  assign rx_own  = (s_ff.rxt.src == SCM_SRC_PIN) ? s_ff.rx_clk_sync[1] : div_clk;
  assign tx_base = (s_ff.txt.src == SCM_SRC_OTHER) ? rx_own : tx_own;
  assign rx_base = (s_ff.rxt.src == SCM_SRC_OTHER) ? tx_own : rx_own;
  assign tx_int  = tx_base ^ s_ff.txt.flip;
  assign rx_int  = rx_base ^ s_ff.rxt.flip;
  assign tx_rise = tx_int & ~s_ff.tx_int_q;
  assign rx_rise = rx_int & ~s_ff.rx_int_q;

  // frame sync edges seen on the synchronised pins
  assign tx_fs_rise = s_ff.tx_fs_sync[1] & ~s_ff.tx_fs_q;
  assign tx_fs_fall = ~s_ff.tx_fs_sync[1] & s_ff.tx_fs_q;
  assign rx_fs_rise = s_ff.rx_fs_sync[1] & ~s_ff.rx_fs_q;
  assign rx_fs_fall = ~s_ff.rx_fs_sync[1] & s_ff.rx_fs_q;

  // start events; sync start follows the other side's registered start
  assign tx_go = s_ff.tx_en && s_ff.tx.fsm == SCM_IDLE && s_ff.tx.full &&
                 start_hit(s_ff.txt.start, tx_fs_rise, tx_fs_fall, s_ff.rx_go_q);
  assign rx_go = s_ff.rx_en && s_ff.rx.fsm == SCM_IDLE &&
                 start_hit(s_ff.rxt.start, rx_fs_rise, rx_fs_fall, s_ff.tx_go_q);

  assign setup  = psel & ~penable;
  assign access = psel & penable;

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_s = s_ff;
    // two-flop synchronisers for pins
    nxt_s.tx_clk_sync = {s_ff.tx_clk_sync[0], tx_pins_in.clk_i};
    nxt_s.rx_clk_sync = {s_ff.rx_clk_sync[0], rx_pins_in.clk_i};
    nxt_s.tx_fs_sync  = {s_ff.tx_fs_sync[0], tx_pins_in.fs_i};
    nxt_s.rx_fs_sync  = {s_ff.rx_fs_sync[0], rx_pins_in.fs_i};
    nxt_s.rx_dat_sync = {s_ff.rx_dat_sync[0], rx_data_i};
    nxt_s.tx_fs_q     = s_ff.tx_fs_sync[1];
    nxt_s.rx_fs_q     = s_ff.rx_fs_sync[1];
    nxt_s.tx_int_q    = tx_int;
    nxt_s.rx_int_q    = rx_int;
    nxt_s.tx_go_q     = tx_go;
    nxt_s.rx_go_q     = rx_go;

    // transmit sequencer: load word, shift msb first on internal rising edge
    if (!s_ff.tx_en) begin
      nxt_s.tx.fsm = SCM_IDLE;
    end else if (tx_go) begin
      nxt_s.tx.fsm   = SCM_RUN;
      nxt_s.tx.cnt   = s_ff.txt.len_m1;
      nxt_s.tx.shift = s_ff.tx.hold << (5'd31 - s_ff.txt.len_m1);
      nxt_s.tx.full  = 1'b0;
      nxt_s.pend[0]  = 1'b1;
    end else if (s_ff.tx.fsm == SCM_RUN && tx_rise) begin
      nxt_s.tx.shift = {s_ff.tx.shift[30:0], 1'b0};
      if (s_ff.tx.cnt == 5'd0) begin
        nxt_s.tx.fsm = SCM_IDLE;
      end else begin
        nxt_s.tx.cnt = s_ff.tx.cnt - 5'd1;
      end
    end

    // receive sequencer: sample on internal rising edge, word to holding
    if (!s_ff.rx_en) begin
      nxt_s.rx.fsm = SCM_IDLE;
    end else if (rx_go) begin
      nxt_s.rx.fsm  = SCM_RUN;
      nxt_s.rx.cnt  = s_ff.rxt.len_m1;
      nxt_s.pend[1] = 1'b1;
    end

    // apb setup phase: read data and error are registered here
    if (setup) begin
      nxt_s.pslverr = !addr_known(paddr);
      if (paddr == `SCM_CTRL_OFS) begin
        nxt_s.prdata = {30'h0, s_ff.tx_en, s_ff.rx_en};
      end else if (paddr == `SCM_DIV_OFS) begin
        nxt_s.prdata = {20'h0, s_ff.div};
      end else if (paddr == `SCM_RXT_OFS) begin
        nxt_s.prdata = {18'h0, s_ff.rxt};
      end else if (paddr == `SCM_TXT_OFS) begin
        nxt_s.prdata = {18'h0, s_ff.txt};
      end else if (paddr == `SCM_RXH_OFS) begin
        nxt_s.prdata = s_ff.rx.hold;
      end else if (paddr == `SCM_TXH_OFS) begin
        nxt_s.prdata = s_ff.tx.hold;
      end else if (paddr == `SCM_STAT_OFS) begin
        nxt_s.prdata = {25'h0, s_ff.pend, s_ff.rx.full, s_ff.rx.fsm == SCM_RUN,
                        s_ff.tx.full, s_ff.tx.fsm == SCM_RUN};
      end else if (paddr == `SCM_MASK_OFS) begin
        nxt_s.prdata = {29'h0, s_ff.mask};
      end else begin
        nxt_s.prdata = 32'h0;
      end
    end

    // apb access phase: writes and read side effects
    if (access && pwrite) begin
      if (paddr == `SCM_CTRL_OFS) begin
        nxt_s.rx_en = pwdata[`SCM_CTRL_RXEN];
        nxt_s.tx_en = pwdata[`SCM_CTRL_TXEN];
      end else if (paddr == `SCM_DIV_OFS) begin
        nxt_s.div = pwdata[`SCM_DIV_W-1:0];
      end else if (paddr == `SCM_RXT_OFS) begin
        nxt_s.rxt = scm_timing_t'(pwdata[13:0]);
      end else if (paddr == `SCM_TXT_OFS) begin
        nxt_s.txt = scm_timing_t'(pwdata[13:0]);
      end else if (paddr == `SCM_TXH_OFS) begin
        nxt_s.tx.hold = pwdata;
        nxt_s.tx.full = 1'b1;
      end else if (paddr == `SCM_MASK_OFS) begin
        nxt_s.mask = pwdata[`SCM_PEND_W-1:0];
      end
    end else if (access) begin
      if (paddr == `SCM_RXH_OFS) begin
        nxt_s.rx.full = 1'b0;
      end else if (paddr == `SCM_STAT_OFS) begin
        nxt_s.pend = 3'h0;
      end
    end

    // event sets come after the clears so a same-cycle set wins
    if (tx_go) begin
      nxt_s.pend[0] = 1'b1;
    end
    if (rx_go) begin
      nxt_s.pend[1] = 1'b1;
    end
    // completed receive word offered to dma
    if (s_ff.rx_en && s_ff.rx.fsm == SCM_RUN && rx_rise) begin
      nxt_s.rx.shift = {s_ff.rx.shift[30:0], s_ff.rx_dat_sync[1]};
      if (s_ff.rx.cnt == 5'd0) begin
        nxt_s.rx.fsm  = SCM_IDLE;
        nxt_s.rx.hold = {s_ff.rx.shift[30:0], s_ff.rx_dat_sync[1]};
        nxt_s.rx.full = 1'b1;
        if (s_ff.rx.full) begin
          nxt_s.pend[2] = 1'b1;
        end
      end else begin
        nxt_s.rx.cnt = s_ff.rx.cnt - 5'd1;
      end
    end

    // clock pin drive for both sides; own pin with continuous drive undefined
    nxt_s.txo.clk_o  = tx_base;
    nxt_s.txo.clk_oe = (s_ff.txt.drv == SCM_DRV_CONT) ||
                       (s_ff.txt.drv == SCM_DRV_XFER && nxt_s.tx.fsm == SCM_RUN);
    nxt_s.rxo.clk_o  = rx_base;
    nxt_s.rxo.clk_oe = (s_ff.rxt.drv == SCM_DRV_CONT) ||
                       (s_ff.rxt.drv == SCM_DRV_XFER && nxt_s.rx.fsm == SCM_RUN);
    // frame sync direction from config, data pins one way
    nxt_s.txo.fs_o   = nxt_s.tx.fsm == SCM_RUN;
    nxt_s.txo.fs_oe  = s_ff.txt.fs_out;
    nxt_s.rxo.fs_o   = nxt_s.rx.fsm == SCM_RUN;
    nxt_s.rxo.fs_oe  = s_ff.rxt.fs_out;
    nxt_s.txo.data_o = (nxt_s.tx.fsm == SCM_RUN) ? nxt_s.tx.shift[31] : 1'b0;
    nxt_s.rxo.data_o = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata      = s_ff.prdata;
  assign pslverr     = s_ff.pslverr & access;
  assign pready      = 1'b1;
  assign tx_pins_out = s_ff.txo;
  assign rx_pins_out = s_ff.rxo;
  assign tx_dma_req  = s_ff.tx_en & ~s_ff.tx.full;
  assign rx_dma_req  = s_ff.rx.full;
  // any pending unmasked source raises the line
  assign irq         = |(s_ff.pend & s_ff.mask);

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_tx_src_div: assert property (
    s_ff.txt.src == SCM_SRC_DIV |=> tx_pins_out.clk_o == $past(div_clk))
    else $error("transmit pin clock does not follow the divider");
  chk_rx_src_tx: assert property (
    s_ff.rxt.src == SCM_SRC_OTHER && s_ff.txt.src == SCM_SRC_DIV |=> rx_pins_out.clk_o == $past(div_clk))
    else $error("receive clock does not follow the transmit clock");
  chk_tx_flip_pin: assert property (
    s_ff.txt.flip |=> tx_pins_out.clk_o != $past(tx_int))
    else $error("transmit inversion leaked onto the pin");
  chk_rx_flip_pin: assert property (
    s_ff.rxt.flip |=> rx_pins_out.clk_o != $past(rx_int))
    else $error("receive inversion leaked onto the pin");
  chk_tx_oe_mode: assert property (
    s_ff.txt.drv == SCM_DRV_OFF ##1 $stable(s_ff.txt) |-> !tx_pins_out.clk_oe)
    else $error("transmit clock pin driven while output is off");
  chk_rx_oe_xfer: assert property (
    s_ff.rxt.drv == SCM_DRV_XFER && s_ff.rx.fsm == SCM_IDLE && !rx_go |=> !rx_pins_out.clk_oe)
    else $error("receive clock pin driven outside a transfer");
  chk_sync_start: assert property (
    tx_go && s_ff.rxt.start == SCM_GO_SYNC && s_ff.rx_en && s_ff.rx.fsm == SCM_IDLE && !rx_go
      |=> ##1 s_ff.rx.fsm == SCM_RUN)
    else $error("receiver did not start with the transmitter");
  chk_irq_pend: assert property (
    $rose(s_ff.pend[1]) && s_ff.mask[1] |-> irq)
    else $error("unmasked pending source without interrupt");
  chk_rx_word_done: assert property (
    $rose(s_ff.rx.full) |-> $past(s_ff.rx.fsm) == SCM_RUN && s_ff.rx.fsm == SCM_IDLE)
    else $error("receive word completed outside a transfer");

  cov_tx_word: cover property (s_ff.tx.fsm == SCM_RUN ##[1:300] s_ff.tx.fsm == SCM_IDLE);
  cov_rx_overrun: cover property ($rose(s_ff.pend[2]));
  cov_sync_pair: cover property (tx_go ##2 s_ff.rx.fsm == SCM_RUN);
endmodule

// ---- tb/scm_far_end.sv ----
// far-end serial device model: clock, frame sync and data pins
`timescale 1ns/100ps
module scm_far_end (
  input  wire logic                  pclk,
  input  wire logic                  ext_on,
  input  wire logic                  ext_tx,
  input  wire scm_pkg::scm_pin_out_t tx_pins_out,
  input  wire scm_pkg::scm_pin_out_t rx_pins_out,
  output scm_pkg::scm_pin_in_t       tx_pins_in,
  output scm_pkg::scm_pin_in_t       rx_pins_in,
  output logic                       rx_data_i
);
  import scm_pkg::*;
  // half period of the external clock in bus cycles
  localparam int HALF = 4;
  int   cnt;
  logic ext_clk;
  logic churn;
  initial begin
    cnt = 0;
    ext_clk = 1'b0;
    churn = 1'b0;
  end
  // external clock ratio
  // clock runs at bus clock over 8, inside both pin limits; still when off
  always @(posedge pclk) begin
    churn <= ~churn;
    if (!ext_on) begin
      cnt <= 0;
      ext_clk <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      ext_clk <= ~ext_clk;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // clock pin levels: device drive wins, then our clock, else a changing pattern; frame sync pins low when undriven
  always_comb begin
    tx_pins_in.clk_i = tx_pins_out.clk_oe ? tx_pins_out.clk_o : (ext_on && ext_tx) ? ext_clk : churn;
    rx_pins_in.clk_i = rx_pins_out.clk_oe ? rx_pins_out.clk_o : (ext_on && !ext_tx) ? ext_clk : churn;
    tx_pins_in.fs_i = tx_pins_out.fs_oe ? tx_pins_out.fs_o : 1'b0;
    rx_pins_in.fs_i = rx_pins_out.fs_oe ? rx_pins_out.fs_o : 1'b0;
    rx_data_i = churn;
  end
endmodule

// ---- tb/test_sync_serial_clock_management.sv ----
// self-checking bench for the serial clock management block
`timescale 1ns/100ps
`include "scm_regs.svh"
module test_sync_serial_clock_management;
  import scm_pkg::*;
  logic         pclk;
  logic         presetn;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [7:0]   paddr;
  logic [31:0]  pwdata;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         tx_dma_req;
  logic         rx_dma_req;
  logic         irq;
  logic         rx_data_i;
  logic         ext_on;
  logic         ext_tx;
  logic [31:0]  q;
  logic         err;
  logic         seen;
  logic         dseen;
  scm_pin_in_t  tx_pins_in;
  scm_pin_in_t  rx_pins_in;
  scm_pin_out_t tx_pins_out;
  scm_pin_out_t rx_pins_out;
  int           miscompares;
  int           checked;
  int           r1;
  int           r2;
  int           t;
  int           diff;
  int           divs [4] = '{1, 2, 3, 5};

  scm_core dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .tx_pins_in, .rx_pins_in, .rx_data_i, .tx_pins_out, .rx_pins_out, .tx_dma_req,
    .rx_dma_req, .irq);
  scm_far_end far_u (.pclk, .ext_on, .ext_tx, .tx_pins_out, .rx_pins_out, .tx_pins_in,
    .rx_pins_in, .rx_data_i);

  ////////////////////////////////////////////////////////////////////////////
  // clock generation
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // compare one value and count it
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer: setup cycle, then access until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // build a timing word from source, drive mode and inversion
  function automatic logic [31:0] tw(scm_src_t s, scm_drv_t d, logic f);
    return {27'h0, f, d, s};
  endfunction

  // sample the clock pins for a window and measure two whole levels
  task automatic runs(input logic rx);
    logic s [64];
    int   a;
    int   b;
    int   c;
    t = 0;
    diff = 0;
    for (int i = 0; i < 64; i++) begin
      @(posedge pclk);
      s[i] = rx ? rx_pins_out.clk_o : tx_pins_out.clk_o;
      if (tx_pins_out.clk_o !== rx_pins_out.clk_o) diff++;
      if (i > 0 && s[i] !== s[i-1]) t++;
    end
    a = 1;
    while (a < 63 && s[a] === s[0]) a++;
    b = a + 1;
    while (b < 63 && s[b] === s[a]) b++;
    c = b + 1;
    while (c < 63 && s[c] === s[b]) c++;
    r1 = b - a;
    r2 = c - b;
  endtask

  // print counts and verdict, then stop
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog against a hung handshake
  initial begin
    #150000;
    miscompares++;
    final_report;
  end

  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, ext_on, ext_tx} = '0;
    presetn = 1'b0;
    miscompares = 0;
    checked = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    check("tx pins at reset", tx_pins_out, 5'h00);
    check("rx pins at reset", rx_pins_out, 5'h00);
    apb(1'b0, `SCM_DIV_OFS, 32'h0);
    check("div reset", q, 32'h0);
    apb(1'b0, `SCM_TXT_OFS, 32'h0);
    check("txt reset", q, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    check("unmapped err", err, 1'b1);
    check("unmapped data", q, 32'h0);
    wr(`SCM_DIV_OFS, 32'hffffffff);
    apb(1'b0, `SCM_DIV_OFS, 32'h0);
    check("div width", q, 32'h00000fff);
    // divider idle at zero, both pins driven continuously
    wr(`SCM_DIV_OFS, 32'h0);
    wr(`SCM_TXT_OFS, tw(SCM_SRC_DIV, SCM_DRV_CONT, 1'b0));
    wr(`SCM_RXT_OFS, tw(SCM_SRC_DIV, SCM_DRV_CONT, 1'b0));
    repeat (10) @(posedge pclk);
    runs(1'b0);
    check("idle divider edges", t, 0);
    check("tx cont oe", tx_pins_out.clk_oe, 1'b1);
    check("rx cont oe", rx_pins_out.clk_oe, 1'b1);
    // level lengths for odd and even divide values
    foreach (divs[k]) begin
      wr(`SCM_DIV_OFS, divs[k]);
      repeat (10) @(posedge pclk);
      runs(1'b0);
      check("div level", r1, divs[k]);
      check("div next level", r2, divs[k]);
      check("tx rx same clock", diff, 0);
    end
    // inversion leaves the pins alone
    wr(`SCM_TXT_OFS, tw(SCM_SRC_DIV, SCM_DRV_CONT, 1'b1));
    repeat (10) @(posedge pclk);
    runs(1'b0);
    check("tx flip pin", diff, 0);
    check("tx flip level", r1, 5);
    // transmit back to plain so a leak on the receive pin shows as a difference
    wr(`SCM_TXT_OFS, tw(SCM_SRC_DIV, SCM_DRV_CONT, 1'b0));
    wr(`SCM_RXT_OFS, tw(SCM_SRC_DIV, SCM_DRV_CONT, 1'b1));
    repeat (10) @(posedge pclk);
    runs(1'b1);
    check("rx flip pin", diff, 0);
    // transmit from own pin, receive takes the other side
    // own pin source never paired with continuous drive
    wr(`SCM_TXT_OFS, tw(SCM_SRC_PIN, SCM_DRV_OFF, 1'b0));
    wr(`SCM_RXT_OFS, tw(SCM_SRC_OTHER, SCM_DRV_CONT, 1'b0));
    ext_tx <= 1'b1;
    ext_on <= 1'b1;
    repeat (12) @(posedge pclk);
    check("tx off oe", tx_pins_out.clk_oe, 1'b0);
    runs(1'b1);
    check("rx from tx pin", r1, 4);
    check("rx from tx pin next", r2, 4);
    // receive from own pin, transmit takes the other side
    ext_tx <= 1'b0;
    wr(`SCM_RXT_OFS, tw(SCM_SRC_PIN, SCM_DRV_OFF, 1'b0));
    wr(`SCM_TXT_OFS, tw(SCM_SRC_OTHER, SCM_DRV_CONT, 1'b0));
    repeat (12) @(posedge pclk);
    check("rx off oe", rx_pins_out.clk_oe, 1'b0);
    runs(1'b0);
    check("tx from rx pin", r1, 4);
    check("rx data out", rx_pins_out.data_o, 1'b0);
    ext_on <= 1'b0;
    // clock pin driven only while a word shifts out
    wr(`SCM_DIV_OFS, 32'h1);
    wr(`SCM_TXT_OFS, tw(SCM_SRC_DIV, SCM_DRV_XFER, 1'b0));
    wr(`SCM_CTRL_OFS, 32'h2);
    repeat (4) @(posedge pclk);
    check("xfer idle oe", tx_pins_out.clk_oe, 1'b0);
    check("tx dma req", tx_dma_req, 1'b1);
    wr(`SCM_TXH_OFS, 32'h1);
    seen = 1'b0;
    dseen = 1'b0;
    repeat (40) begin
      @(posedge pclk);
      seen = seen | tx_pins_out.clk_oe;
      dseen = dseen | tx_pins_out.data_o;
    end
    check("xfer oe seen", seen, 1'b1);
    check("xfer oe ended", tx_pins_out.clk_oe, 1'b0);
    check("tx data bit", dseen, 1'b1);
    // pending tx start stays silent until unmasked; status read clears it
    check("irq masked", irq, 1'b0);
    wr(`SCM_MASK_OFS, 32'h1);
    @(posedge pclk);
    check("irq unmasked", irq, 1'b1);
    apb(1'b0, `SCM_STAT_OFS, 32'h0);
    check("stat tx start", q, 32'h00000010);
    @(posedge pclk);
    check("irq cleared", irq, 1'b0);
    check("rx dma idle", rx_dma_req, 1'b0);
    // receiver runs one-bit words back to back with no reads: full and overrun
    wr(`SCM_RXT_OFS, tw(SCM_SRC_DIV, SCM_DRV_XFER, 1'b0));
    wr(`SCM_CTRL_OFS, 32'h3);
    repeat (20) @(posedge pclk);
    check("rx dma req", rx_dma_req, 1'b1);
    check("irq other masked", irq, 1'b0);
    apb(1'b0, `SCM_STAT_OFS, 32'h0);
    check("stat rx", q & 32'hfffffffb, 32'h00000068);
    final_report;
  end
endmodule
